//--- rtl/ebt_pkg.sv
// package for the eight-bit reload timer with waveform output
package ebt_pkg;
  // register word offsets (byte address = index * 4)
  localparam logic [11:0] IDX_PORT_SEL = 12'h00a;
  localparam logic [11:0] IDX_CLK_GATE = 12'h00d;
  localparam logic [11:0] IDX_MODE_CLK = 12'h010;
  localparam logic [11:0] IDX_MODE_OUT = 12'h011;
  localparam logic [11:0] IDX_LOAD_LO = 12'h012;
  localparam logic [11:0] IDX_LOAD_HI = 12'h013;
  localparam logic [11:0] IDX_IRQ_STAT = 12'h020;
  localparam logic [11:0] IDX_IRQ_MASK = 12'h021;
  // field positions
  localparam int BIT_RELOAD = 3;
  localparam int BIT_EVT_PIN = 0;
  localparam int BIT_OUT_PIN = 3;
  localparam int BIT_STANDBY = 0;
  localparam int BIT_PWM = 2;
  // edge select codes (mode_output[1:0])
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  // clock select codes
  localparam logic [2:0] CSEL_2048 = 3'h0;
  localparam logic [2:0] CSEL_512 = 3'h1;
  localparam logic [2:0] CSEL_128 = 3'h2;
  localparam logic [2:0] CSEL_EVT = 3'h7;
  // instruction cycle and periods in instruction cycles
  localparam int TCYC_CLKS = 4;
  localparam int PER_2048 = 2048;
  localparam int PER_512 = 512;
  localparam int PER_128 = 128;
  localparam int MODE_DELAY_INSN = 2;
  localparam int MODE_DELAY_CLKS = MODE_DELAY_INSN * TCYC_CLKS;
  localparam logic [7:0] CNT_TOP = 8'hff;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [3:0] NIB_ZERO = 4'h0;
endpackage : ebt_pkg

//--- rtl/ebt_timer.sv
// eight-bit reload timer with event input, toggle/pwm output, wishbone regs
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// R01: count up by one per input clock
// R02: overflow at FF, reload or zero
// R03: overflow sets sticky flag until cleared
// R04: load write starts count from value
// R05: event input counts pin edges, pin enabled
// R06: event edge falling, rising or both
// R07: source keeps both-edge spacing two cycles
// R08: output pin enable bit 3, mode select
// R09: toggle output inverts on overflow
// R10: free-run pwm duty changes next frame
// R11: reload pwm restarts frame on write
// R12: standby bit stops counter, keeps modes
// R13: clock mode register four bits, reset zero
// R14: clock mode applies two instructions later
// R15: software writes load after mode settles
// R16: select 2048, 512 or 128 cycle periods
// R17: low nibble staged, high nibble loads
// R18: high read latches low nibble
// R19: event pin synchronised before edge detect
module ebt_timer
  import ebt_pkg::*;
#(
  parameter int TCYC = TCYC_CLKS // system clocks per instruction cycle
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [13:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // pins
  input wire logic event_count_pin_i,
  output logic waveform_out_pin_o,
  output logic waveform_out_pin_oe_o,
  // interrupt
  output logic irq_o
);

  // prescaler width follows the longest period, so any tcyc ratio fits
  localparam int PW = $clog2(PER_2048 * TCYC);

  // registers
  logic [3:0] port_sel_q; // port_function_select_two
  logic [3:0] clk_gate_q; // module_clock_gate_one
  logic [3:0] mode_clk_wr_q; // written mode, not yet in force
  logic [3:0] mode_clk_q; // mode in force
  logic [3:0] mode_out_q;
  logic [3:0] load_lo_q;
  logic [3:0] load_hi_q;
  logic [3:0] cap_lo_q; // latched low nibble
  logic [7:0] cnt_q;
  logic [7:0] duty_q; // compare value used in current pwm frame
  logic wave_q;
  logic irq_stat_q;
  logic irq_mask_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic [3:0] mdly_q; // mode settle countdown
  logic [PW-1:0] pre_q; // prescaler
  logic [2:0] evt_sync_q; // three-stage pin synchroniser

  // bus timing in short:
  // - a request is taken on the edge where cyc and stb are high and
  //   no answer is pending, so every access has one wait state
  // - writes land on that taking edge; the master sees ack one edge later
  // - read data is registered and stands only while ack stands
  // - the !ack_q term keeps a held request from being taken twice
  // - unmapped addresses still answer, reads give zero, writes vanish
  // - mode and load registers are write-only, mode reads give zero and
  //   the capture pair shares the load pair's addresses
  // bus decode
  wire logic req = cyc_i && stb_i && !ack_q;
  wire logic [11:0] idx = adr_i[13:2];
  wire logic wr = req && we_i && sel_i[0];
  wire logic rd = req && !we_i;
  wire logic wr_load_hi = wr && idx == IDX_LOAD_HI;
  wire logic wr_load_lo = wr && idx == IDX_LOAD_LO;
  wire logic wr_mode_clk = wr && idx == IDX_MODE_CLK;
  wire logic rd_cap_hi = rd && idx == IDX_LOAD_HI;

  // gating and mode fields
  wire logic standby = clk_gate_q[BIT_STANDBY];
  wire logic reload_sel = mode_clk_q[BIT_RELOAD];
  wire logic [2:0] csel = mode_clk_q[2:0];
  wire logic pwm_mode = mode_out_q[BIT_PWM];
  wire logic [1:0] edge_sel = mode_out_q[1:0];
  wire logic [7:0] load_val = {load_hi_q, load_lo_q};

  // prescaler tap selection: ticks once per selected period
  function automatic logic [PW-1:0] period_clks(input logic [2:0] c);
    unique case (c)
      CSEL_512: period_clks = PW'(PER_512 * TCYC - 1);
      CSEL_128: period_clks = PW'(PER_128 * TCYC - 1);
      default: period_clks = PW'(PER_2048 * TCYC - 1);
    endcase
  endfunction : period_clks

  // prescaler hits terminal count; >= also catches a shortened period
  wire logic pre_tick = pre_q >= period_clks(csel); // see R16

  // event edge detect on second and third stages only
  wire logic evt_rise = evt_sync_q[1] && !evt_sync_q[2]; // see R19
  wire logic evt_fall = !evt_sync_q[1] && evt_sync_q[2]; // see R19
  wire logic evt_hit = (edge_sel == EDGE_FALL && evt_fall) ||
    (edge_sel == EDGE_RISE && evt_rise) ||
    (edge_sel == EDGE_BOTH && (evt_rise || evt_fall)); // see R06
  wire logic evt_mode = csel == CSEL_EVT && port_sel_q[BIT_EVT_PIN];

  // selected count pulse
  wire logic cnt_tick = !standby &&
    (evt_mode ? evt_hit : (csel != CSEL_EVT && pre_tick)); // see R05
  wire logic ovf = cnt_tick && cnt_q == CNT_TOP; // see R02

  // bus answer and control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
      port_sel_q <= NIB_ZERO;
      clk_gate_q <= NIB_ZERO;
      mode_clk_wr_q <= NIB_ZERO; // see R13
      mode_out_q <= NIB_ZERO;
      load_lo_q <= NIB_ZERO;
      load_hi_q <= NIB_ZERO;
      irq_mask_q <= 1'b0;
      cap_lo_q <= NIB_ZERO;
    end else begin
      ack_q <= req; // one wait cycle, unmapped answers too
      if (wr) begin
        unique case (idx)
          IDX_PORT_SEL: port_sel_q <= dat_i[3:0];
          IDX_CLK_GATE: clk_gate_q <= dat_i[3:0];
          IDX_MODE_CLK: mode_clk_wr_q <= dat_i[3:0];
          IDX_MODE_OUT: mode_out_q <= dat_i[3:0];
          IDX_LOAD_LO: load_lo_q <= dat_i[3:0]; // see R17
          IDX_LOAD_HI: load_hi_q <= dat_i[3:0];
          IDX_IRQ_MASK: irq_mask_q <= dat_i[0];
          default: ;
        endcase
      end
      if (rd_cap_hi) cap_lo_q <= cnt_q[3:0]; // see R18
      dat_q <= 32'h0;
      if (rd) begin
        unique case (idx)
          IDX_PORT_SEL: dat_q <= {28'h0, port_sel_q};
          IDX_CLK_GATE: dat_q <= {28'h0, clk_gate_q};
          IDX_LOAD_LO: dat_q <= {28'h0, cap_lo_q}; // see R18
          IDX_LOAD_HI: dat_q <= {28'h0, cnt_q[7:4]}; // see R18
          IDX_IRQ_STAT: dat_q <= {31'h0, irq_stat_q};
          IDX_IRQ_MASK: dat_q <= {31'h0, irq_mask_q};
          default: dat_q <= 32'h0;
        endcase
      end
    end
  end

  // mode register settles two instruction times after write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_clk_q <= NIB_ZERO;
      mdly_q <= 4'h0;
    end else if (wr_mode_clk) begin
      mdly_q <= 4'(MODE_DELAY_INSN * TCYC); // see R14
    end else if (mdly_q != 4'h0) begin
      mdly_q <= mdly_q - 4'h1;
      if (mdly_q == 4'h1) mode_clk_q <= mode_clk_wr_q; // see R14
    end
  end

  // prescaler and pin synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_q <= '0;
      evt_sync_q <= 3'h0;
    end else begin
      evt_sync_q <= {evt_sync_q[1:0], event_count_pin_i}; // see R19
      if (standby || pre_tick) pre_q <= '0; // see R12
      else pre_q <= pre_q + PW'(1);
    end
  end

  // pwm frames in short:
  // - a frame starts at overflow, or at a load write in reload pwm
  // - the wave is low from frame start until the count meets the duty
  //   compare value, then high until the frame ends
  // - free-running pwm takes a new duty only at the next overflow,
  //   so a write keeps the running duty but still sets the count
  // - reload pwm restarts at once from the written value
  // counter, pwm frame compare and output wave
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= CNT_ZERO;
      duty_q <= CNT_ZERO;
      wave_q <= 1'b0;
    end else if (wr_load_hi) begin
      cnt_q <= {dat_i[3:0], load_lo_q}; // see R04
      if (pwm_mode && reload_sel) begin
        duty_q <= {dat_i[3:0], load_lo_q}; // see R11
        wave_q <= 1'b0;
      end
    end else if (ovf) begin
      cnt_q <= reload_sel ? load_val : CNT_ZERO; // see R02
      if (pwm_mode) begin
        duty_q <= load_val; // see R10
        wave_q <= 1'b0;
      end else begin
        wave_q <= !wave_q; // see R09
      end
    end else if (cnt_tick) begin
      cnt_q <= cnt_q + 8'h1; // see R01
      // wave rises when the count meets the frame's duty value
      if (pwm_mode && cnt_q == duty_q) wave_q <= 1'b1; // see R10 R11
    end
  end

  // sticky interrupt flag, set wins over write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) irq_stat_q <= 1'b0;
    else if (ovf) irq_stat_q <= 1'b1; // see R03
    else if (wr && idx == IDX_IRQ_STAT && dat_i[0]) irq_stat_q <= 1'b0;
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;
  assign irq_o = irq_stat_q && irq_mask_q;
  assign waveform_out_pin_o = wave_q;
  assign waveform_out_pin_oe_o = port_sel_q[BIT_OUT_PIN]; // see R08

  // assertions
  property p_count;
    @(posedge clk_i) disable iff (rst_i)
      cnt_tick && !ovf && !wr_load_hi |=> cnt_q == $past(cnt_q) + 8'h1;
  endproperty
  a_count: assert property (p_count) else $error("count step"); // see R01
  property p_ovf;
    @(posedge clk_i) disable iff (rst_i) ovf && !wr_load_hi |=>
      cnt_q == ($past(reload_sel) ? $past(load_val) : CNT_ZERO);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow load"); // see R02
  property p_flag;
    @(posedge clk_i) disable iff (rst_i) ovf |=> irq_stat_q;
  endproperty
  a_flag: assert property (p_flag) else $error("flag not set"); // see R03
  property p_load;
    @(posedge clk_i) disable iff (rst_i)
      wr_load_hi |=> cnt_q == {$past(dat_i[3:0]), $past(load_lo_q)};
  endproperty
  a_load: assert property (p_load) else $error("load value"); // see R04
  property p_lo_nochg;
    @(posedge clk_i) disable iff (rst_i)
      wr_load_lo && !cnt_tick |=> cnt_q == $past(cnt_q);
  endproperty
  a_lo_nochg: assert property (p_lo_nochg) else $error("low write"); // see R17
  property p_toggle;
    @(posedge clk_i) disable iff (rst_i)
      ovf && !pwm_mode && !wr_load_hi |=> wave_q != $past(wave_q);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle"); // see R09
  property p_standby;
    @(posedge clk_i) disable iff (rst_i) standby |-> !cnt_tick;
  endproperty
  a_standby: assert property (p_standby) else $error("standby"); // see R12
  property p_mode_dly;
    @(posedge clk_i) disable iff (rst_i)
      wr_mode_clk ##1 !wr_mode_clk [*7] |=> mode_clk_q == mode_clk_wr_q;
  endproperty
  a_mode_dly: assert property (p_mode_dly) else $error("mode delay"); // see R14
  property p_oe;
    @(posedge clk_i) disable iff (rst_i)
      waveform_out_pin_oe_o == port_sel_q[BIT_OUT_PIN];
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable"); // see R08

  // the flag holds until a write of one clears it
  property p_flag_hold;
    @(posedge clk_i) disable iff (rst_i)
      irq_stat_q && !(wr && idx == IDX_IRQ_STAT && dat_i[0]) |=> irq_stat_q;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost"); // see R03

  // the event pin counts nothing unless its function is enabled
  property p_evt_gate;
    @(posedge clk_i) disable iff (rst_i)
      csel == CSEL_EVT && !port_sel_q[BIT_EVT_PIN] |-> !cnt_tick;
  endproperty
  a_evt_gate: assert property (p_evt_gate) else $error("pin gate"); // see R05

  // each qualified edge is one count pulse from settled stages
  property p_evt_sync;
    @(posedge clk_i) disable iff (rst_i)
      evt_hit |-> evt_sync_q[1] != evt_sync_q[2];
  endproperty
  a_evt_sync: assert property (p_evt_sync) else $error("edge sync"); // see R19

  // every pwm frame opens with the wave low
  property p_pwm_frame;
    @(posedge clk_i) disable iff (rst_i)
      pwm_mode && ovf && !wr_load_hi |=> !wave_q;
  endproperty
  a_pwm_frame: assert property (p_pwm_frame) else $error("frame"); // see R10

  // free-running pwm keeps the running duty across a load write
  property p_pwm_next;
    @(posedge clk_i) disable iff (rst_i)
      pwm_mode && !reload_sel && wr_load_hi |=> duty_q == $past(duty_q);
  endproperty
  a_pwm_next: assert property (p_pwm_next) else $error("duty"); // see R10

  // reload pwm restarts the frame on the load write
  property p_pwm_reload;
    @(posedge clk_i) disable iff (rst_i)
      pwm_mode && reload_sel && wr_load_hi |=>
        !wave_q && duty_q == {$past(dat_i[3:0]), $past(load_lo_q)};
  endproperty
  a_pwm_reload: assert property (p_pwm_reload) else $error("restart"); // see R11

  // the upper read captures the lower count nibble
  property p_capture;
    @(posedge clk_i) disable iff (rst_i)
      rd_cap_hi |=> cap_lo_q == $past(cnt_q[3:0]);
  endproperty
  a_capture: assert property (p_capture) else $error("capture"); // see R18

  // the prescaler drives the count whenever it is the source
  property p_prescale;
    @(posedge clk_i) disable iff (rst_i)
      pre_tick && !standby && csel != CSEL_EVT |-> cnt_tick;
  endproperty
  a_prescale: assert property (p_prescale) else $error("prescale"); // see R16

  // the answer is a one-cycle pulse
  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i) ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack width");

  // main scenarios reached
  c_ovf: cover property (@(posedge clk_i) disable iff (rst_i) ovf);
  c_pwm: cover property (@(posedge clk_i) disable iff (rst_i)
    pwm_mode && wave_q);
  c_evt: cover property (@(posedge clk_i) disable iff (rst_i)
    evt_mode && evt_hit);
  c_rd: cover property (@(posedge clk_i) disable iff (rst_i) rd_cap_hi);

endmodule : ebt_timer
`default_nettype wire

//--- verification/ebt_partner.sv
// event source and pin load that face the timer in the bench
`timescale 1ns/1ns
`default_nettype none
module ebt_partner (
  // clock
  input wire logic clk_i,
  // timer pins
  input wire logic wave_i,
  input wire logic wave_oe_i,
  output var logic evt_o,
  output wire logic lvl_o
);
  // the pin is pulled up while the timer leaves it undriven
  assign lvl_o = wave_oe_i ? wave_i : 1'b1;
  initial evt_o = 1'b0;
  // each level lasts 10 clocks, well over the both-edge spacing
  task automatic pulse(input int n);
    repeat (n) begin
      repeat (10) @(posedge clk_i);
      evt_o <= 1'b1;
      repeat (10) @(posedge clk_i);
      evt_o <= 1'b0;
    end
  endtask : pulse
endmodule : ebt_partner
`default_nettype wire

//--- verification/eight_bit_reload_timer_pwm_bench.sv
// self-checking bench for the eight-bit reload timer
`timescale 1ns/1ns
`default_nettype none
module eight_bit_reload_timer_pwm_bench;
  import ebt_pkg::*;
  logic clk_i = 1'b0; // system clock
  logic rst_i = 1'b1; // held for 20 cycles
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [13:0] adr_i = 14'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o, irq_o, evt, wave, wave_oe;
  logic [31:0] seed = 32'h4be1f3ab; // lfsr state
  int num_errors = 0;
  int checked = 0;
  always #10 clk_i = ~clk_i;
  // timer with one system clock per instruction cycle
  ebt_timer #(.TCYC(1)) dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'h1),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .event_count_pin_i(evt), .waveform_out_pin_o(wave),
    .waveform_out_pin_oe_o(wave_oe), .irq_o(irq_o));
  ebt_partner pm (.clk_i(clk_i), .wave_i(wave), .wave_oe_i(wave_oe),
    .evt_o(evt), .lvl_o());
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // count after n pulses from s, reloading s on overflow
  function automatic logic [7:0] ev_exp(input logic [7:0] s, input int n);
    logic [7:0] c;
    c = s;
    for (int i = 0; i < n; i++) c = (c == CNT_TOP) ? s : c + 8'h1;
    return c;
  endfunction : ev_exp
  task automatic conclude();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    checked++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask : chk
  // one classic cycle; held until ack is sampled, then released
  task automatic wb(input logic w, input logic [11:0] idx,
                    input logic [3:0] d, output logic [3:0] q);
    int i;
    i = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'h0};
    dat_i <= {28'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1 && ++i < 50);
    if (i >= 50) begin
      num_errors++;
      conclude();
    end
    q = dat_o[3:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb
  // upper read first latches the lower nibble
  task automatic rdc(output logic [7:0] c);
    wb(1'b0, IDX_LOAD_HI, 4'h0, c[7:4]);
    wb(1'b0, IDX_LOAD_LO, 4'h0, c[3:0]);
  endtask : rdc
  task automatic load(input logic [7:0] v);
    logic [3:0] q;
    wb(1'b1, IDX_LOAD_LO, v[3:0], q);
    wb(1'b1, IDX_LOAD_HI, v[7:4], q);
  endtask : load
  initial begin
    logic [3:0] q;
    logic [7:0] c, c0, v;
    logic l0;
    int n;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, IDX_MODE_CLK, 4'h0, q);
    chk("mode_clock read", 8'h00, {4'h0, q});
    wb(1'b1, IDX_PORT_SEL, 4'h9, q);
    wb(1'b1, IDX_MODE_CLK, {1'b1, CSEL_EVT}, q);
    repeat (20) @(posedge clk_i); // mode settles first
    seed = lfsr(seed);
    v = seed[7:0];
    rdc(c0);
    wb(1'b1, IDX_LOAD_LO, v[3:0], q);
    rdc(c);
    chk("count after low write", c0, c);
    wb(1'b1, IDX_LOAD_HI, v[7:4], q);
    rdc(c);
    chk("count after load", v, c);
    // every edge code with a random number of pulses
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      n = 1 + seed[1:0];
      wb(1'b1, IDX_MODE_OUT, {2'h0, 2'(k)}, q);
      load(seed[15:8]);
      pm.pulse(n);
      repeat (10) @(posedge clk_i);
      rdc(c);
      v = ev_exp(seed[15:8], k == 2 ? 2 * n : n);
      chk("event count", v, c);
    end
    // overflow with reload, toggle wave and interrupt
    wb(1'b1, IDX_MODE_OUT, {2'h0, EDGE_RISE}, q);
    load(8'hfe);
    l0 = pm.lvl_o;
    pm.pulse(2);
    repeat (10) @(posedge clk_i);
    rdc(c);
    chk("reload on overflow", 8'hfe, c);
    chk("toggle wave", {7'h0, ~l0}, {7'h0, pm.lvl_o});
    wb(1'b0, IDX_IRQ_STAT, 4'h0, q);
    chk("irq status", 8'h01, {7'h0, q[0]});
    chk("irq masked", 8'h00, {7'h0, irq_o});
    wb(1'b1, IDX_IRQ_MASK, 4'h1, q);
    chk("irq raised", 8'h01, {7'h0, irq_o});
    wb(1'b1, IDX_IRQ_STAT, 4'h1, q);
    wb(1'b0, IDX_IRQ_STAT, 4'h0, q);
    chk("irq cleared", 8'h00, {7'h0, irq_o | q[0]});
    // free-running overflow goes to zero
    wb(1'b1, IDX_MODE_CLK, {1'b0, CSEL_EVT}, q);
    repeat (20) @(posedge clk_i);
    load(8'hff);
    pm.pulse(1);
    repeat (10) @(posedge clk_i);
    rdc(c);
    chk("free-run wrap", 8'h00, c);
    // reload pwm: low from the load write, high at duty, low at overflow
    wb(1'b1, IDX_MODE_CLK, {1'b1, CSEL_EVT}, q);
    repeat (20) @(posedge clk_i);
    wb(1'b1, IDX_MODE_OUT, {2'h1, EDGE_RISE}, q);
    load(8'hfd);
    chk("pwm start", 8'h00, {7'h0, pm.lvl_o});
    pm.pulse(1);
    repeat (10) @(posedge clk_i);
    chk("pwm high", 8'h01, {7'h0, pm.lvl_o});
    pm.pulse(2);
    repeat (10) @(posedge clk_i);
    chk("pwm frame", 8'h00, {7'h0, pm.lvl_o});
    // divide by 128 instruction cycles
    wb(1'b1, IDX_MODE_CLK, {1'b0, CSEL_128}, q);
    repeat (20) @(posedge clk_i);
    load(8'h00);
    repeat (300) @(posedge clk_i);
    rdc(c);
    chk("prescaled count", 8'h01, {7'h0, c == 2 || c == 3});
    // standby stops the prescaled count
    wb(1'b1, IDX_CLK_GATE, 4'h1, q);
    rdc(c0);
    repeat (300) @(posedge clk_i);
    rdc(c);
    chk("standby hold", c0, c);
    wb(1'b1, IDX_CLK_GATE, 4'h0, q);
    conclude();
  end
endmodule : eight_bit_reload_timer_pwm_bench
`default_nettype wire
